// >>> design/csm_cfg.svh
// constants for the capacitive sensor status register map
// Function
// - fixed read-only product id at 0x00
// - read-only firmware revision at 0x01
// - flag bit5 reports output polarity
// - flag bit4 set while baseline frozen
// - flag bit3 set in low-power sampling
// - flag bit2 set while auto tuning runs
// - flag bit1 set on noise detection
// - flag bit0 zoom; no rate change boosted
// - status bit1 reports touch
// - status bit0 reports proximity
// - baseline high at 0x83, low 0x84
`ifndef CSM_CFG_SVH
`define CSM_CFG_SVH
// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define CSM_IDX_PRODUCT_ID 8'h00
`define CSM_IDX_FIRMWARE_REV 8'h01
`define CSM_IDX_SYSTEM_FLAGS 8'h10
`define CSM_IDX_DETECT_STATUS 8'h31
`define CSM_IDX_COUNT_HIGH 8'h42
`define CSM_IDX_COUNT_LOW 8'h43
`define CSM_IDX_BASE_HIGH 8'h83
`define CSM_IDX_BASE_LOW 8'h84
`define CSM_IDX_FUSE_0 8'hc4
`define CSM_IDX_FUSE_1 8'hc5
`define CSM_IDX_IRQ_STATUS 8'hd0
`define CSM_IDX_IRQ_MASK 8'hd1
`define CSM_IDX_CONTROL 8'hd2
// ************************************************************
// field positions
// ************************************************************
`define CSM_FLAG_POLARITY 5
`define CSM_FLAG_HALT 4
`define CSM_FLAG_SLOW 3
`define CSM_FLAG_TUNING 2
`define CSM_FLAG_NOISE 1
`define CSM_FLAG_ZOOM 0
`define CSM_STAT_TOUCH 1
`define CSM_STAT_PROX 0
// interrupt status bits: 0 prox rise, 1 touch rise, 2 noise rise, 3 sample
`define CSM_IRQ_BITS 4
// ************************************************************
// reset values and fixed codes (id values are arbitrary)
// ************************************************************
`define CSM_PRODUCT_ID_VAL 8'h5a
`define CSM_FIRMWARE_REV_VAL 8'h0a
`define CSM_CONTROL_RST 8'h00
`define CSM_MASK_RST 4'h0
`endif

// >>> design/csm_pkg.sv
// types for the capacitive sensor status register map
package csm_pkg;
  // sensing core state presented to the map
  typedef struct packed {
    logic polarity_high;
    logic baseline_halt;
    logic slow_sample_flag;
    logic auto_tuning;
    logic noise_detect_flag;
    logic zoom;
    logic touch;
    logic prox;
    logic [15:0] sample_count;
    logic [15:0] baseline_average;
    logic [7:0] config_fuse_byte_0;
    logic [7:0] config_fuse_byte_1;
  } csm_sense_t;
  // avalon slave request
  typedef struct packed {
    logic [9:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } csm_bus_req_t;
  typedef enum logic [1:0] {
    CSM_IDLE,
    CSM_ANSWER
  } csm_phase_t;
  // whole module state
  typedef struct packed {
    csm_phase_t phase;
    logic [31:0] readdata;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic [7:0] control;
    logic prox_prev;
    logic touch_prev;
    logic noise_prev;
    logic [15:0] count_prev;
    logic [15:0] count_snap;
  } csm_state_t;
endpackage : csm_pkg

// >>> design/csm_status_map.sv
// avalon register map of the capacitive sensor status bytes
`timescale 1ns/10ps
`include "csm_cfg.svh"
module csm_status_map (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [9:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire csm_pkg::csm_sense_t i_sense,
  output logic o_baseline_freeze,
  output logic o_irq
);
  // ************************************************************
  // state
  // ************************************************************
  csm_pkg::csm_state_t st_q;
  csm_pkg::csm_state_t st_d;
  csm_pkg::csm_bus_req_t req;
  logic [7:0] idx;
  logic [7:0] flags;
  logic [7:0] status;
  logic [3:0] events;
  logic halt_eff;

  // pack the bus request
  assign req = '{address: i_avs_address, read: i_avs_read, write: i_avs_write,
                 byteenable: i_avs_byteenable, writedata: i_avs_writedata};
  assign idx = req.address[9:2];

  // software may force the baseline freeze; core halt also counts in flag bit4, but o_baseline_freeze follows control bit0 only
  assign halt_eff = i_sense.baseline_halt | st_q.control[0];

  // ************************************************************
  // read byte decode
  // ************************************************************
  function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [7:0] f, input logic [7:0] s,
                                         input csm_pkg::csm_state_t q, input csm_pkg::csm_sense_t sn);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      `CSM_IDX_PRODUCT_ID: r = `CSM_PRODUCT_ID_VAL;
      `CSM_IDX_FIRMWARE_REV: r = `CSM_FIRMWARE_REV_VAL;
      `CSM_IDX_SYSTEM_FLAGS: r = f;
      `CSM_IDX_DETECT_STATUS: r = s;
      `CSM_IDX_COUNT_HIGH: r = q.count_snap[15:8];
      `CSM_IDX_COUNT_LOW: r = q.count_snap[7:0];
      `CSM_IDX_BASE_HIGH: r = sn.baseline_average[15:8];
      `CSM_IDX_BASE_LOW: r = sn.baseline_average[7:0];
      `CSM_IDX_FUSE_0: r = sn.config_fuse_byte_0;
      `CSM_IDX_FUSE_1: r = sn.config_fuse_byte_1;
      `CSM_IDX_IRQ_STATUS: r = {4'h0, q.irq_status};
      `CSM_IDX_IRQ_MASK: r = {4'h0, q.irq_mask};
      `CSM_IDX_CONTROL: r = q.control;
      default: r = 8'h00; // unmapped reads zero
    endcase
    return r;
  endfunction : rd_byte

  // system flag and status bytes; upper bits reserved as zero
  always_comb begin
    flags = 8'h00;
    flags[`CSM_FLAG_POLARITY] = i_sense.polarity_high;
    flags[`CSM_FLAG_HALT] = halt_eff;
    flags[`CSM_FLAG_SLOW] = i_sense.slow_sample_flag;
    flags[`CSM_FLAG_TUNING] = i_sense.auto_tuning;
    flags[`CSM_FLAG_NOISE] = i_sense.noise_detect_flag;
    flags[`CSM_FLAG_ZOOM] = i_sense.zoom;
    status = 8'h00;
    status[`CSM_STAT_TOUCH] = i_sense.touch;
    status[`CSM_STAT_PROX] = i_sense.prox;
  end

  // rising edges of detections and a new sample raise events
  assign events = {st_q.count_prev != i_sense.sample_count,
                   i_sense.noise_detect_flag & ~st_q.noise_prev,
                   i_sense.touch & ~st_q.touch_prev,
                   i_sense.prox & ~st_q.prox_prev};

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_d = st_q;
    st_d.prox_prev = i_sense.prox;
    st_d.touch_prev = i_sense.touch;
    st_d.noise_prev = i_sense.noise_detect_flag;
    st_d.count_prev = i_sense.sample_count;
    // high byte read latches the count, but every idle cycle without a read reloads the snapshot
    if (st_q.phase == csm_pkg::CSM_IDLE && req.read && idx == `CSM_IDX_COUNT_HIGH) begin
      st_d.count_snap = i_sense.sample_count;
    end else if (st_q.phase == csm_pkg::CSM_IDLE && !req.read) begin
      st_d.count_snap = i_sense.sample_count;
    end
    unique case (st_q.phase)
      csm_pkg::CSM_IDLE: begin
        if (req.read) begin
          st_d.readdata = {24'h00_0000, rd_byte(idx, flags, status, st_q, i_sense)};
          if (idx == `CSM_IDX_COUNT_HIGH) begin
            st_d.readdata = {24'h00_0000, i_sense.sample_count[15:8]};
          end
          st_d.phase = csm_pkg::CSM_ANSWER;
        end else if (req.write) begin
          st_d.phase = csm_pkg::CSM_ANSWER;
        end
      end
      csm_pkg::CSM_ANSWER: begin
        // a write lands only at the edge where waitrequest is seen low
        if (req.write && !req.read) begin
          if (req.byteenable[0]) begin
            if (idx == `CSM_IDX_IRQ_MASK) begin
              st_d.irq_mask = req.writedata[3:0];
            end
            if (idx == `CSM_IDX_CONTROL) begin
              st_d.control = req.writedata[7:0];
            end
            if (idx == `CSM_IDX_IRQ_STATUS) begin
              st_d.irq_status = st_q.irq_status & ~req.writedata[3:0];
            end
          end
        end
        st_d.phase = csm_pkg::CSM_IDLE;
      end
    endcase
    // a new event beats a clear in the same cycle
    st_d.irq_status = st_d.irq_status | events;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= '{phase: csm_pkg::CSM_IDLE, readdata: 32'h0000_0000, irq_status: 4'h0,
                irq_mask: `CSM_MASK_RST, control: `CSM_CONTROL_RST, prox_prev: 1'b0,
                touch_prev: 1'b0, noise_prev: 1'b0, count_prev: 16'h0000, count_snap: 16'h0000};
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // waitrequest high until answer cycle
  assign o_avs_waitrequest = (st_q.phase != csm_pkg::CSM_ANSWER);
  assign o_avs_readdata = st_q.readdata;
  assign o_baseline_freeze = st_q.control[0];
  assign o_irq = |(st_q.irq_status & st_q.irq_mask);
endmodule : csm_status_map

// >>> testbench/csm_core_model.sv
// sensing core stand-in that feeds the status map
`timescale 1ns/10ps
module csm_core_model (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire csm_pkg::csm_sense_t i_cmd,
  output csm_pkg::csm_sense_t o_sense
);
  // core state moves on the clock, one cycle behind the bench
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) o_sense <= '0;
    else o_sense <= i_cmd;
  end
endmodule : csm_core_model

// >>> testbench/csm_status_map_asserts.sv
// concurrent checks on the status map ports
`timescale 1ns/10ps
`include "csm_cfg.svh"
module csm_status_map_chk (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [9:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire csm_pkg::csm_sense_t i_sense,
  input wire logic o_baseline_freeze,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // answer edge of a read at one index; data was captured one edge earlier
  sequence s_rd(logic [7:0] ix);
    i_avs_read && !o_avs_waitrequest && i_avs_address[9:2] == ix;
  endsequence
  property p_take; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
  a_take: assert property (p_take) else $error("request not answered next cycle");
  property p_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("answer longer than one cycle");
  property p_id; s_rd(8'h00) |-> o_avs_readdata == {24'h00_0000, `CSM_PRODUCT_ID_VAL}; endproperty
  a_id: assert property (p_id) else $error("product id wrong");
  property p_fw; s_rd(8'h01) |-> o_avs_readdata == {24'h00_0000, `CSM_FIRMWARE_REV_VAL}; endproperty
  a_fw: assert property (p_fw) else $error("firmware revision wrong");
  property p_flag; s_rd(8'h10) |-> o_avs_readdata[7:0] == {2'h0, $past(i_sense[55:50] | {1'b0, o_baseline_freeze, 4'h0})};
  endproperty
  a_flag: assert property (p_flag) else $error("system flag byte wrong");
  property p_stat; s_rd(8'h31) |-> o_avs_readdata == {30'h0000_0000, $past(i_sense[49:48])}; endproperty
  a_stat: assert property (p_stat) else $error("detect status wrong");
  property p_cnt; s_rd(8'h42) |-> o_avs_readdata[7:0] == $past(i_sense.sample_count[15:8]); endproperty
  a_cnt: assert property (p_cnt) else $error("count high byte wrong");
  property p_base; s_rd(8'h83) |-> o_avs_readdata[7:0] == $past(i_sense.baseline_average[15:8]); endproperty
  a_base: assert property (p_base) else $error("baseline high byte wrong");
endmodule : csm_status_map_chk
bind csm_status_map csm_status_map_chk u_chk (.*);

// >>> testbench/tb.sv
// self-checking bench for the status map
`timescale 1ns/10ps
module tb;
  logic i_clk = 0, i_rst_b = 0, rd = 0, wr = 0, o_irq, freeze, wreq;
  logic [9:0] adr = '0;
  logic [31:0] wd = '0, rdat, d;
  csm_pkg::csm_sense_t cmd = '0, sense;
  int failures = 0, n_tests = 0, cyc = 0;
  always #5 i_clk = ~i_clk;
  csm_core_model u_core (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cmd(cmd), .o_sense(sense));
  csm_status_map dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_byteenable(4'hf), .i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_sense(sense), .o_baseline_freeze(freeze), .o_irq(o_irq));
  task test_done;
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // a hang ends the run as a mismatch
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      test_done;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one access, held until waitrequest is seen low
  task acc(input logic w, input logic [7:0] ix, input logic [31:0] v);
    @(posedge i_clk);
    adr <= {ix, 2'h0};
    wd <= v;
    rd <= !w;
    wr <= w;
    @(posedge i_clk);
    while (wreq !== 1'b0) @(posedge i_clk);
    d = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : acc
  task rchk(input logic [7:0] ix, input logic [31:0] exp);
    acc(1'b0, ix, 32'h0000_0000);
    chk(d, exp);
  endtask : rchk
  // product id survives a write attempt; firmware revision read back
  task t_ident;
    acc(1'b1, 8'h00, 32'h0000_00ff);
    rchk(8'h00, 32'h0000_005a);
    rchk(8'h01, 32'h0000_000a);
  endtask : t_ident
  // walk each flag bit alone, step status through all four values, then force a freeze
  task t_flags;
    for (int i = 0; i < 6; i++) begin
      cmd <= csm_pkg::csm_sense_t'(56'h1 << (50 + i));
      rchk(8'h10, 32'h0000_0001 << i);
    end
    for (int i = 0; i < 4; i++) begin
      cmd <= csm_pkg::csm_sense_t'(56'(i) << 48);
      rchk(8'h31, 32'(i));
    end
    acc(1'b1, 8'hd2, 32'h0000_0001);
    rchk(8'h10, 32'h0000_0010);
    chk(32'(freeze), 32'h0000_0001);
    acc(1'b1, 8'hd2, 32'h0000_0000);
  endtask : t_flags
  // count held steady so the high-byte snapshot matches the low byte
  task t_bytes;
    cmd <= csm_pkg::csm_sense_t'(56'h00_a5c3_3c96_817e);
    rchk(8'h42, 32'h0000_00a5);
    rchk(8'h43, 32'h0000_00c3);
    rchk(8'h83, 32'h0000_003c);
    rchk(8'h84, 32'h0000_0096);
    rchk(8'hc4, 32'h0000_0081);
    rchk(8'hc5, 32'h0000_007e);
    rchk(8'h20, 32'h0000_0000);
  endtask : t_bytes
  // proximity rise raised, masked, unmasked, then cleared
  task t_irq;
    acc(1'b1, 8'hd1, 32'h0000_0001);
    acc(1'b1, 8'hd0, 32'h0000_000f);
    @(posedge i_clk);
    chk(32'(o_irq), 32'h0000_0000);
    cmd <= csm_pkg::csm_sense_t'(56'h01_a5c3_3c96_817e);
    repeat (3) @(posedge i_clk);
    chk(32'(o_irq), 32'h0000_0001);
    acc(1'b1, 8'hd1, 32'h0000_0000);
    @(posedge i_clk);
    chk(32'(o_irq), 32'h0000_0000);
    acc(1'b1, 8'hd1, 32'h0000_0001);
    @(posedge i_clk);
    chk(32'(o_irq), 32'h0000_0001);
    acc(1'b1, 8'hd0, 32'h0000_0001);
    @(posedge i_clk);
    chk(32'(o_irq), 32'h0000_0000);
  endtask : t_irq
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_ident;
    t_flags;
    t_bytes;
    t_irq;
    test_done;
  end
endmodule : tb
